// >>> secure_zone_access_control.sv
// Access control engine for a secure serial memory, reached over Wishbone
//
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none

module secure_zone_access_control (
	input  wire logic        CORE_CLK,     // 100 MHz core clock
	input  wire logic        RST_N,        // Reset pin, active low
	input  wire logic        WB_CYC_I,     // Bus cycle
	input  wire logic        WB_STB_I,     // Bus strobe
	input  wire logic        WB_WE_I,      // Write enable
	input  wire logic [7:0]  WB_ADR_I,     // Byte address
	input  wire logic [3:0]  WB_SEL_I,     // Byte lanes
	input  wire logic [31:0] WB_DAT_I,     // Write data
	output logic      [31:0] WB_DAT_O,     // Read data
	output logic             WB_ACK_O,     // Acknowledge
	input  wire logic        PWR_LOSS,     // Supply lost, asynchronous
	output logic             BUSY,         // Engine busy, host must poll
	output logic      [1:0]  SEC_MODE,     // Communication security mode
	output logic             TEAR_PENDING  // Buffered copy not yet finished
);

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic [1:0] rst_pipe;
	logic       rst_n;

	// Release through two stages so all state leaves reset on one edge
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic                          ack;
		logic [31:0]                   rdat;
		logic                          pwr_meta;
		logic                          pwr_loss;
		logic [4:0]                    ctrl;
		logic [31:0]                   zone_cfg;
		logic [3:0][31:0]              data;
		logic                          error;
		secure_zone_pkg::mode_type     mode;
		logic                          pw_active;
		logic                          pw_write;
		logic [2:0]                    pw_set;
		logic                          sc_ok;
		logic                          enc_payload;
		logic [7:0]                    rdata;
		logic [7:0]                    mdc;
		logic [7:0][2:0]               pw_trials;
		logic [3:0][2:0]               key_trials;
		secure_zone_pkg::engine_type   state;
		logic [6:0]                    base;
		logic [4:0]                    len;
		logic [4:0]                    idx;
		logic                          single;
		logic                          tear_pending;
		logic [6:0]                    tear_addr;
		logic [4:0]                    tear_len;
		logic [15:0][7:0]              stage;
		logic [15:0][23:0]             pw_store;
		logic [127:0][7:0]             mem;
	} state_type;

	state_type r;
	state_type next;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic        req;
		logic        bus_wr;
		logic [31:0] wmask;
		logic [31:0] wval;
		logic [3:0]  op;
		logic [2:0]  set;
		logic [6:0]  ca;
		logic [7:0]  zc;
		logic [7:0]  old;
		logic [7:0]  nb;
		logic [7:0]  lock;
		logic [7:0]  val;
		logic        deny;
		logic        super_ok;
		logic [31:0] rd;
		req      = WB_CYC_I & WB_STB_I;
		bus_wr   = req & WB_WE_I & r.ack;
		wmask    = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
		wval     = WB_DAT_I & wmask;
		op       = WB_DAT_I[secure_zone_pkg::CMD_OP +: 4];
		set      = WB_DAT_I[secure_zone_pkg::CMD_IDX +: 3];
		ca       = 7'(r.base + 7'(r.idx));
		zc       = r.zone_cfg[8 * ca[6:5] +: 8];
		old      = r.mem[ca];
		nb       = r.data[r.idx[3:2]][8 * r.idx[1:0] +: 8];
		lock     = r.mem[{ca[6:3], 3'b000}];
		val      = nb;
		deny     = 1'b0;
		super_ok = 1'b0;
		rd       = 32'h0000_0000;
		next     = r;

		// Registered ack: answer one cycle after the request, drop after one
		next.ack      = req & ~r.ack;
		next.pwr_meta = PWR_LOSS;
		next.pwr_loss = r.pwr_meta;

		// Read mux, latched with the ack so data is stable while ack is high
		unique case (WB_ADR_I & 8'hFC)
			secure_zone_pkg::ADDR_CTRL:      rd = {27'h000_0000, r.ctrl};
			secure_zone_pkg::ADDR_ZONE_CFG:  rd = r.zone_cfg;
			secure_zone_pkg::ADDR_STATUS: begin
				rd = {r.mdc, r.rdata, 3'h0, r.enc_payload, r.tear_pending, r.sc_ok,
				      r.pw_set, r.pw_write, r.pw_active, 1'b0, r.mode, r.error,
				      r.state != secure_zone_pkg::ST_IDLE};
			end
			secure_zone_pkg::ADDR_PW_TRIALS: rd = {8'h00, r.pw_trials};
			secure_zone_pkg::ADDR_KEY_TRIAL: rd = {20'h0_0000, r.key_trials};
			default: begin
				if (WB_ADR_I >= secure_zone_pkg::ADDR_DATA0 &&
				    WB_ADR_I <= (secure_zone_pkg::ADDR_DATA3 | 8'h03)) begin
					rd = r.data[WB_ADR_I[3:2]];
				end
			end
		endcase
		if (req & ~r.ack) begin
			next.rdat = rd;
		end

		// Register writes take effect on the edge that drops the ack, one cycle after it rises
		if (bus_wr) begin
			unique case (WB_ADR_I & 8'hFC)
				secure_zone_pkg::ADDR_CTRL: begin
					next.ctrl = (r.ctrl & ~wmask[4:0]) | wval[4:0];
				end
				secure_zone_pkg::ADDR_ZONE_CFG: begin
					next.zone_cfg = (r.zone_cfg & ~wmask) | wval;
				end
				secure_zone_pkg::ADDR_STATUS: begin
					// Write one to clear; a new error later in this cycle wins
					if (wval[secure_zone_pkg::ST_ERROR]) begin
						next.error = 1'b0;
					end
				end
				default: begin
					if (WB_ADR_I >= secure_zone_pkg::ADDR_DATA0 &&
					    WB_ADR_I <= (secure_zone_pkg::ADDR_DATA3 | 8'h03)) begin
						next.data[WB_ADR_I[3:2]] = (r.data[WB_ADR_I[3:2]] & ~wmask) | wval;
					end
				end
			endcase
		end

		// Power-up event: volatile security state is lost, standard mode
		if (bus_wr && (WB_ADR_I & 8'hFC) == secure_zone_pkg::ADDR_CTRL &&
		    wval[secure_zone_pkg::CTRL_POWER_UP]) begin
			next.mode      = secure_zone_pkg::MODE_STANDARD;
			next.pw_active = 1'b0;
			next.sc_ok     = 1'b0;
			if (r.state != secure_zone_pkg::ST_IDLE) begin
				next.error = 1'b1;
			end else if (r.tear_pending) begin
				// Replay the interrupted copy from the buffer
				next.idx   = 5'h00;
				next.state = secure_zone_pkg::ST_COPY;
			end
		end

		// Command issue; only one command runs at a time
		if (bus_wr && (WB_ADR_I & 8'hFC) == secure_zone_pkg::ADDR_CMD) begin
			if (r.state != secure_zone_pkg::ST_IDLE) begin
				next.error = 1'b1;
			end else begin
				unique case (op)
					secure_zone_pkg::OP_WRITE: begin
						next.base   = WB_DAT_I[secure_zone_pkg::CMD_ADDR +: 7];
						next.len    = 5'(WB_DAT_I[secure_zone_pkg::CMD_LEN +: 4]) + 5'h01;
						next.idx    = 5'h00;
						next.mdc    = 8'h00;
						next.single = r.zone_cfg[8 * WB_DAT_I[secure_zone_pkg::CMD_ADDR + 5 +: 2]
						              + secure_zone_pkg::ZC_WLOCK];
						next.enc_payload = r.mode == secure_zone_pkg::MODE_ENCRYPT;
						if (r.ctrl[secure_zone_pkg::CTRL_ANTI_TEAR] &&
						    next.len > secure_zone_pkg::TEAR_MAX_BYTES) begin
							next.error = 1'b1;
						end else begin
							next.state = secure_zone_pkg::ST_CHECK;
						end
					end
					secure_zone_pkg::OP_READ: begin
						ca = WB_DAT_I[secure_zone_pkg::CMD_ADDR +: 7];
						zc = r.zone_cfg[8 * ca[6:5] +: 8];
						// Encryption-required zone is closed outside encryption mode
						deny = (zc[secure_zone_pkg::ZC_ENC_REQ] &
						        r.mode != secure_zone_pkg::MODE_ENCRYPT) |
						       (zc[secure_zone_pkg::ZC_PW_REQ] & ~(r.pw_active &
						        r.pw_set == zc[secure_zone_pkg::ZC_SET +: 3]));
						next.rdata = deny ? 8'h00 : r.mem[ca];
						next.enc_payload = r.mode == secure_zone_pkg::MODE_ENCRYPT;
						if (deny) begin
							next.error = 1'b1;
						end
					end
					secure_zone_pkg::OP_VERIFY_PW: begin
						next.enc_payload = r.mode == secure_zone_pkg::MODE_ENCRYPT;
						if (r.pw_trials[set] >= secure_zone_pkg::TRIALS_LIMIT) begin
							next.error = 1'b1;
						end else if (r.pw_store[{set, WB_DAT_I[secure_zone_pkg::CMD_RW]}] ==
						             r.data[0][23:0]) begin
							// One active password; a new one replaces the old
							next.pw_active    = 1'b1;
							next.pw_set       = set;
							next.pw_write     = WB_DAT_I[secure_zone_pkg::CMD_RW];
							next.pw_trials[set] = 3'h0;
						end else begin
							next.pw_active      = 1'b0;
							next.pw_trials[set] = r.pw_trials[set] + 3'h1;
							next.error          = 1'b1;
						end
					end
					secure_zone_pkg::OP_SET_PW: begin
						super_ok = r.ctrl[secure_zone_pkg::CTRL_SUPER_EN] & r.pw_active &
						           r.pw_write &
						           r.pw_set == r.ctrl[secure_zone_pkg::CTRL_SUPER_SET +: 3];
						if (r.sc_ok || super_ok) begin
							next.pw_store[{set, WB_DAT_I[secure_zone_pkg::CMD_RW]}] =
								r.data[0][23:0];
						end else begin
							next.error = 1'b1;
						end
					end
					secure_zone_pkg::OP_AUTH: begin
						if (r.key_trials[set[1:0]] >= secure_zone_pkg::TRIALS_LIMIT) begin
							next.error = 1'b1;
						end else if (WB_DAT_I[secure_zone_pkg::CMD_OUTCOME]) begin
							next.mode = secure_zone_pkg::MODE_AUTH;
							next.key_trials[set[1:0]] = 3'h0;
						end else begin
							// Failed request cancels any earlier success
							next.mode  = secure_zone_pkg::MODE_STANDARD;
							next.key_trials[set[1:0]] = r.key_trials[set[1:0]] + 3'h1;
							next.error = 1'b1;
						end
					end
					secure_zone_pkg::OP_ENC_ACT: begin
						if (r.mode != secure_zone_pkg::MODE_STANDARD &&
						    WB_DAT_I[secure_zone_pkg::CMD_OUTCOME]) begin
							next.mode = secure_zone_pkg::MODE_ENCRYPT;
						end else begin
							next.error = 1'b1;
						end
					end
					secure_zone_pkg::OP_TAG_FAIL: begin
						// Tag only matters in secure modes; mismatch drops the mode
						if (r.mode != secure_zone_pkg::MODE_STANDARD) begin
							next.mode  = secure_zone_pkg::MODE_STANDARD;
							next.error = 1'b1;
						end
					end
					secure_zone_pkg::OP_SECURE_CODE: begin
						next.sc_ok = r.data[0][23:0] == secure_zone_pkg::SECURE_CODE;
						if (r.data[0][23:0] != secure_zone_pkg::SECURE_CODE) begin
							next.error = 1'b1;
						end
					end
					default: begin
						next.error = 1'b1;
					end
				endcase
			end
		end

		// ************************************************************
		// Write engine
		// ************************************************************
		unique case (r.state)
			secure_zone_pkg::ST_IDLE: begin
			end
			secure_zone_pkg::ST_CHECK: begin
				// Write-lock zones keep only the first byte
				if (r.pwr_loss) begin
					next.state = secure_zone_pkg::ST_IDLE;
				end else if (r.idx < r.len && !(r.single && r.idx != 5'h00)) begin
					deny = zc[secure_zone_pkg::ZC_NO_MODIFY] |
					       (zc[secure_zone_pkg::ZC_ENC_REQ] &
					        r.mode != secure_zone_pkg::MODE_ENCRYPT) |
					       (zc[secure_zone_pkg::ZC_PW_REQ] & ~(r.pw_active & r.pw_write &
					        r.pw_set == zc[secure_zone_pkg::ZC_SET +: 3]));
					if (zc[secure_zone_pkg::ZC_WLOCK]) begin
						if (ca[2:0] == 3'h0) begin
							deny = deny | ~lock[0];
							val  = old & nb;
						end else begin
							deny = deny | ~lock[ca[2:0]];
						end
					end
					if (zc[secure_zone_pkg::ZC_PROG_ONLY]) begin
						val = old & nb;
					end
					if (deny) begin
						next.error = 1'b1;
						next.state = secure_zone_pkg::ST_IDLE;
					end else begin
						// Staged value already carries the destination's conditions
						next.stage[r.idx[3:0]] = val;
						next.mdc = r.mdc + nb;
						next.idx = r.idx + 5'h01;
					end
				end else begin
					next.tear_addr    = r.base;
					next.tear_len     = r.idx;
					next.tear_pending = r.ctrl[secure_zone_pkg::CTRL_ANTI_TEAR];
					next.idx          = 5'h00;
					next.state        = secure_zone_pkg::ST_COPY;
				end
			end
			secure_zone_pkg::ST_COPY: begin
				// Power loss stops mid-copy; pending flag keeps the replay armed
				if (r.pwr_loss) begin
					next.state = secure_zone_pkg::ST_IDLE;
				end else if (r.idx == r.tear_len) begin
					next.tear_pending = 1'b0;
					next.state        = secure_zone_pkg::ST_IDLE;
				end else begin
					next.mem[7'(r.tear_addr + 7'(r.idx))] = r.stage[r.idx[3:0]];
					next.idx = r.idx + 5'h01;
				end
			end
			default: begin
				next.state = secure_zone_pkg::ST_IDLE;
			end
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Storage, buffer and passwords are nonvolatile and keep their contents
	always_ff @(posedge CORE_CLK or negedge rst_n) begin
		if (!rst_n) begin
			r.ack          <= 1'b0;
			r.rdat         <= 32'h0000_0000;
			r.pwr_meta     <= 1'b0;
			r.pwr_loss     <= 1'b0;
			r.ctrl         <= secure_zone_pkg::CTRL_RESET;
			r.zone_cfg     <= secure_zone_pkg::ZONE_CFG_RESET;
			r.data         <= '0;
			r.error        <= 1'b0;
			r.mode         <= secure_zone_pkg::MODE_STANDARD;
			r.pw_active    <= 1'b0;
			r.pw_write     <= 1'b0;
			r.pw_set       <= 3'h0;
			r.sc_ok        <= 1'b0;
			r.enc_payload  <= 1'b0;
			r.rdata        <= 8'h00;
			r.mdc          <= 8'h00;
			r.pw_trials    <= '0;
			r.key_trials   <= '0;
			r.state        <= secure_zone_pkg::ST_IDLE;
			r.base         <= 7'h00;
			r.len          <= 5'h00;
			r.idx          <= 5'h00;
			r.single       <= 1'b0;
			r.tear_pending <= 1'b0;
			r.tear_addr    <= 7'h00;
			r.tear_len     <= 5'h00;
		end else begin
			r <= next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign WB_ACK_O     = r.ack;
	assign WB_DAT_O     = r.rdat;
	assign BUSY         = r.state != secure_zone_pkg::ST_IDLE;
	assign SEC_MODE     = r.mode;
	assign TEAR_PENDING = r.tear_pending;

endmodule

`default_nettype wire

// >>> secure_zone_pkg.sv
// Constants, register map and types for the secure zone access control block
package secure_zone_pkg;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_ZONE_CFG  = 8'h04;
	localparam logic [7:0] ADDR_CMD       = 8'h08;
	localparam logic [7:0] ADDR_STATUS    = 8'h0C;
	localparam logic [7:0] ADDR_DATA0     = 8'h10;
	localparam logic [7:0] ADDR_DATA3     = 8'h1C;
	localparam logic [7:0] ADDR_PW_TRIALS = 8'h20;
	localparam logic [7:0] ADDR_KEY_TRIAL = 8'h24;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_ANTI_TEAR = 0;
	localparam int CTRL_SUPER_EN  = 1;
	localparam int CTRL_SUPER_SET = 2;
	localparam int CTRL_POWER_UP  = 8;
	localparam int CMD_OP         = 0;
	localparam int CMD_ADDR       = 4;
	localparam int CMD_LEN        = 11;
	localparam int CMD_IDX        = 15;
	localparam int CMD_RW         = 18;
	localparam int CMD_OUTCOME    = 19;
	localparam int ZC_WLOCK       = 0;
	localparam int ZC_NO_MODIFY   = 1;
	localparam int ZC_PROG_ONLY   = 2;
	localparam int ZC_ENC_REQ     = 3;
	localparam int ZC_SET         = 4;
	localparam int ZC_PW_REQ      = 7;
	localparam int ST_ERROR       = 1;

	// ****************************************************************
	// Reset values and limits
	// ****************************************************************
	localparam logic [4:0]  CTRL_RESET      = 5'h00;
	localparam logic [31:0] ZONE_CFG_RESET  = 32'h0000_0000;
	localparam logic [4:0]  TEAR_MAX_BYTES  = 5'h08;
	localparam logic [2:0]  TRIALS_LIMIT    = 3'h4;
	localparam logic [23:0] SECURE_CODE     = 24'hDD_4297;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [3:0] OP_WRITE       = 4'h1;
	localparam logic [3:0] OP_READ        = 4'h2;
	localparam logic [3:0] OP_VERIFY_PW   = 4'h3;
	localparam logic [3:0] OP_SET_PW      = 4'h4;
	localparam logic [3:0] OP_AUTH        = 4'h5;
	localparam logic [3:0] OP_ENC_ACT     = 4'h6;
	localparam logic [3:0] OP_TAG_FAIL    = 4'h7;
	localparam logic [3:0] OP_SECURE_CODE = 4'h8;

	typedef enum logic [1:0] {MODE_STANDARD, MODE_AUTH, MODE_ENCRYPT} mode_type;
	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_COPY} engine_type;

endpackage

// >>> secure_zone_sva.sv
// Port-level checker for the secure zone access control block
`timescale 1ns/100ps
`default_nettype none
module secure_zone_checker (
	input wire logic       CORE_CLK,    // Core clock
	input wire logic       RST_N,       // Reset, active low
	input wire logic       WB_CYC_I,    // Bus cycle
	input wire logic       WB_STB_I,    // Bus strobe
	input wire logic       WB_WE_I,     // Write enable
	input wire logic       WB_ACK_O,    // Acknowledge
	input wire logic       PWR_LOSS,    // Supply lost
	input wire logic       BUSY,        // Engine busy
	input wire logic [1:0] SEC_MODE,    // Security mode
	input wire logic       TEAR_PENDING // Copy unfinished
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// ********
	// Sequences
	// ********
	sequence req_s;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	// Longest job is sixteen bytes checked then copied
	sequence busy_done_s;
		##[1:40] !BUSY;
	endsequence
	// ********
	// Properties
	// ********
	ack_latency_a: assert property (req_s |=> WB_ACK_O)
		else $error("ack missing after request");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	mode_legal_a: assert property (SEC_MODE != 2'h3)
		else $error("illegal security mode");
	enc_after_auth_a: assert property (SEC_MODE == 2'h0 |=> SEC_MODE != 2'h2)
		else $error("encryption without authentication");
	mode_cause_a: assert property ($changed(SEC_MODE) && SEC_MODE != 2'h0
		|-> $past(WB_ACK_O && WB_WE_I)) else $error("mode rose without a command");
	busy_cause_a: assert property ($rose(BUSY) |-> $past(WB_ACK_O && WB_WE_I))
		else $error("engine started without a command");
	busy_bound_a: assert property ($rose(BUSY) |-> busy_done_s)
		else $error("engine busy too long");
	tear_busy_a: assert property ($rose(TEAR_PENDING) |-> BUSY)
		else $error("copy armed while idle");
	loss_stop_a: assert property (PWR_LOSS [*4] |-> !BUSY)
		else $error("engine ran through supply loss");
endmodule
bind secure_zone_access_control secure_zone_checker i_chk (.CORE_CLK(CORE_CLK),
	.RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ACK_O(WB_ACK_O), .PWR_LOSS(PWR_LOSS), .BUSY(BUSY), .SEC_MODE(SEC_MODE),
	.TEAR_PENDING(TEAR_PENDING));
`default_nettype wire

// >>> secure_zone_host.sv
// Host controller model: classic bus cycles and busy polling
`timescale 1ns/100ps
`default_nettype none
module secure_zone_host (
	input  wire logic        core_clk, // Core clock
	input  wire logic        ack,      // Acknowledge
	input  wire logic [31:0] dat_o,    // Read data
	input  wire logic        busy,     // Device busy
	output var  logic        cyc,      // Bus cycle
	output var  logic        stb,      // Bus strobe
	output var  logic        we,       // Write enable
	output var  logic [7:0]  adr,      // Byte address
	output var  logic [3:0]  sel,      // Byte lanes
	output var  logic [31:0] dat       // Write data
);
	// Idle bus at time zero
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'hFF;
		sel = 4'hF;
		dat = 32'h0000_0000;
	end
	// Request held until ack sampled; released lines never keep old data
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		// No cycle count assumed; only the bench watchdog ends a stuck wait
		while (ack !== 1'b1) @(posedge core_clk);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		adr <= ~a;
		dat <= ~d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		acc(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		acc(1'b0, a, 32'h0000_0000, r);
	endtask
	// Busy polling after writes and power-up replay
	task automatic poll();
		@(posedge core_clk);
		while (busy !== 1'b0) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// >>> secure_zone_access_control_tb_top.sv
// Directed register-level test of the secure zone access control block
`timescale 1ns/100ps
`default_nettype none
module secure_zone_access_control_tb_top;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        pwr_loss = 1'b0;
	logic        cyc, stb, we, ack, busy, tear;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, dat_o, q;
	logic [1:0]  mode;
	int          failures = 0;
	int          checks_done = 0;
	always #5 core_clk = ~core_clk;
	secure_zone_access_control i_dut (.CORE_CLK(core_clk), .RST_N(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .PWR_LOSS(pwr_loss), .BUSY(busy),
		.SEC_MODE(mode), .TEAR_PENDING(tear));
	secure_zone_host i_host (.core_clk(core_clk), .ack(ack), .dat_o(dat_o), .busy(busy),
		.cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat));
	// ********
	// Helpers
	// ********
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (failures == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic run(input logic [3:0] op, input logic [6:0] a, input logic [3:0] n,
		input logic [2:0] s, input logic rw, input logic oc);
		i_host.wr(secure_zone_pkg::ADDR_CMD, {12'h000, oc, rw, s, n, a, op});
		i_host.poll();
	endtask
	task automatic pw(input logic [3:0] op, input logic [2:0] s, input logic rw,
		input logic [31:0] v);
		i_host.wr(secure_zone_pkg::ADDR_DATA0, v);
		run(op, 7'h00, 4'h0, s, rw, 1'b0);
	endtask
	task automatic sr();
		i_host.rd(secure_zone_pkg::ADDR_STATUS, q);
	endtask
	task automatic wbyte(input logic [6:0] a, input logic [7:0] d);
		i_host.wr(secure_zone_pkg::ADDR_DATA0, 32'(d));
		run(secure_zone_pkg::OP_WRITE, a, 4'h0, 3'h0, 1'b0, 1'b0);
	endtask
	task automatic rbyte(input logic [6:0] a, input logic [7:0] e);
		run(secure_zone_pkg::OP_READ, a, 4'h0, 3'h0, 1'b0, 1'b0);
		sr();
		chk(32'(q[23:16]), 32'(e), "read byte");
	endtask
	// Error flag checked then cleared
	task automatic err(input logic e);
		sr();
		chk(32'(q[1]), 32'(e), "error flag");
		i_host.wr(secure_zone_pkg::ADDR_STATUS, 32'h0000_0002);
	endtask
	task automatic md(input logic [3:0] op, input logic oc, input logic [1:0] e);
		run(op, 7'h00, 4'h0, 3'h0, 1'b0, oc);
		chk(32'(mode), 32'(e), "mode");
	endtask
	// Hang guard, well beyond the expected run
	initial begin
		#200_000;
		failures++;
		wrap_up();
	end
	// ********
	// Main sequence
	// ********
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		i_host.rd(secure_zone_pkg::ADDR_CTRL, q);
		chk(q, 32'h0000_0000, "ctrl reset");
		i_host.rd(8'h30, q);
		chk(q, 32'h0000_0000, "unmapped");
		chk(32'(mode), 32'h0000_0000, "mode");
		wbyte(7'h21, 8'h5A);
		sr();
		chk(32'(q[31:24]), 32'h0000_005A, "checksum");
		wbyte(7'h41, 8'hF0);
		wbyte(7'h60, 8'hFF);
		wbyte(7'h61, 8'hAA);
		wbyte(7'h63, 8'h77);
		i_host.wr(secure_zone_pkg::ADDR_ZONE_CFG, 32'h0104_0200);
		wbyte(7'h21, 8'h00);
		err(1'b1);
		rbyte(7'h21, 8'h5A);
		wbyte(7'h41, 8'h30);
		rbyte(7'h41, 8'h30);
		wbyte(7'h41, 8'hCF);
		rbyte(7'h41, 8'h00);
		wbyte(7'h60, 8'hFD);
		wbyte(7'h61, 8'h55);
		rbyte(7'h61, 8'hAA);
		i_host.wr(secure_zone_pkg::ADDR_DATA0, 32'h0000_2211);
		run(secure_zone_pkg::OP_WRITE, 7'h62, 4'h1, 3'h0, 1'b0, 1'b0);
		rbyte(7'h62, 8'h11);
		rbyte(7'h63, 8'h77);
		wbyte(7'h60, 8'hFF);
		rbyte(7'h60, 8'hFD);
		wbyte(7'h60, 8'hFC);
		wbyte(7'h60, 8'hF0);
		rbyte(7'h60, 8'hFC);
		i_host.wr(secure_zone_pkg::ADDR_STATUS, 32'h0000_0002);
		// Nine bytes refused, then eight cut by supply loss mid-copy
		i_host.wr(secure_zone_pkg::ADDR_CTRL, 32'h0000_0001);
		i_host.wr(secure_zone_pkg::ADDR_DATA0, 32'h0302_0100);
		i_host.wr(secure_zone_pkg::ADDR_DATA0 + 8'h04, 32'h0706_0504);
		run(secure_zone_pkg::OP_WRITE, 7'h08, 4'h8, 3'h0, 1'b0, 1'b0);
		err(1'b1);
		i_host.wr(secure_zone_pkg::ADDR_CMD, {12'h000, 5'h00, 4'h7, 7'h08, 4'h1});
		repeat (12) @(posedge core_clk);
		pwr_loss <= 1'b1;
		repeat (4) @(posedge core_clk);
		pwr_loss <= 1'b0;
		chk(32'(tear), 32'h0000_0001, "tear pending");
		chk(32'(busy), 32'h0000_0000, "busy");
		i_host.wr(secure_zone_pkg::ADDR_CTRL, 32'h0000_0100);
		i_host.poll();
		chk(32'(tear), 32'h0000_0000, "tear pending");
		rbyte(7'h0F, 8'h07);
		pw(secure_zone_pkg::OP_SECURE_CODE, 3'h0, 1'b0, 32'h00DD_4296);
		sr();
		chk(32'(q[10]), 32'h0000_0000, "secure code");
		pw(secure_zone_pkg::OP_SECURE_CODE, 3'h0, 1'b0, 32'h00DD_4297);
		sr();
		chk(32'(q[10]), 32'h0000_0001, "secure code");
		pw(secure_zone_pkg::OP_SET_PW, 3'h1, 1'b0, 32'h0012_3456);
		pw(secure_zone_pkg::OP_SET_PW, 3'h2, 1'b1, 32'h0065_4321);
		repeat (4) pw(secure_zone_pkg::OP_VERIFY_PW, 3'h1, 1'b0, 32'h0000_0000);
		pw(secure_zone_pkg::OP_VERIFY_PW, 3'h1, 1'b0, 32'h0012_3456);
		sr();
		chk(32'(q[5]), 32'h0000_0000, "password active");
		i_host.rd(secure_zone_pkg::ADDR_PW_TRIALS, q);
		chk(q, 32'h0000_0020, "trials");
		pw(secure_zone_pkg::OP_VERIFY_PW, 3'h2, 1'b1, 32'h0065_4321);
		sr();
		chk(32'(q[9:5]), 32'h0000_000B, "password state");
		i_host.wr(secure_zone_pkg::ADDR_STATUS, 32'h0000_0002);
		i_host.wr(secure_zone_pkg::ADDR_ZONE_CFG, 32'h0104_02A0);
		rbyte(7'h0F, 8'h07);
		err(1'b0);
		i_host.wr(secure_zone_pkg::ADDR_ZONE_CFG, 32'h0104_0208);
		run(secure_zone_pkg::OP_READ, 7'h0F, 4'h0, 3'h0, 1'b0, 1'b0);
		err(1'b1);
		md(secure_zone_pkg::OP_AUTH, 1'b1, 2'h1);
		md(secure_zone_pkg::OP_AUTH, 1'b0, 2'h0);
		md(secure_zone_pkg::OP_AUTH, 1'b1, 2'h1);
		md(secure_zone_pkg::OP_ENC_ACT, 1'b1, 2'h2);
		rbyte(7'h0F, 8'h07);
		chk(32'(q[12]), 32'h0000_0001, "encrypted payload");
		md(secure_zone_pkg::OP_TAG_FAIL, 1'b0, 2'h0);
		// Reset pin in mid-run drops the held password
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		sr();
		chk(32'(q[5]), 32'h0000_0000, "password active");
		// Supervisor on set two: refused without it, allowed once it is held
		i_host.wr(secure_zone_pkg::ADDR_CTRL, 32'h0000_000A);
		pw(secure_zone_pkg::OP_SET_PW, 3'h3, 1'b0, 32'h00AB_CDEF);
		err(1'b1);
		pw(secure_zone_pkg::OP_VERIFY_PW, 3'h2, 1'b1, 32'h0065_4321);
		pw(secure_zone_pkg::OP_SET_PW, 3'h3, 1'b0, 32'h00AB_CDEF);
		err(1'b0);
		pw(secure_zone_pkg::OP_VERIFY_PW, 3'h3, 1'b0, 32'h00AB_CDEF);
		sr();
		chk(32'(q[9:5]), 32'h0000_000D, "password state");
		wrap_up();
	end
endmodule
`default_nettype wire
